// ==== hdl/atd_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : constants for the antenna tuning and depth register bank
// Assumes : byte-wide registers on an 8-bit register address
// Notes   : offsets are byte addresses on the plain register port
//////////////////////////////////////////////////////////////////////////////
package atd_pkg;

   // register offsets
   localparam logic [7:0] ATD_OFS_TUNE_CTRL   = 8'h21;
   localparam logic [7:0] ATD_OFS_TUNE_TARGET = 8'h22;
   localparam logic [7:0] ATD_OFS_TUNE_RESULT = 8'h23;
   localparam logic [7:0] ATD_OFS_DEPTH_CTRL  = 8'h24;
   localparam logic [7:0] ATD_OFS_DEPTH_RES   = 8'h25;
   localparam logic [7:0] ATD_OFS_DEPTH_SEG   = 8'h26;

   // reset and restore-default values
   localparam logic [7:0] ATD_RST_TUNE_CTRL   = 8'h00;
   localparam logic [7:0] ATD_RST_TUNE_TARGET = 8'h80;
   localparam logic [7:0] ATD_RST_TUNE_RESULT = 8'h00;
   localparam logic [7:0] ATD_RST_DEPTH_CTRL  = 8'h00;
   localparam logic [7:0] ATD_RST_DEPTH_RES   = 8'h00;
   localparam logic [7:0] ATD_RST_DEPTH_SEG   = 8'h00;

   // value written into the depth mask on a failed calibration
   localparam logic [7:0] ATD_DEPTH_FAIL_MASK = 8'hFF;

   // field positions
   localparam int ATD_TUNE_SRC_BIT   = 7;  // tuning source select
   localparam int ATD_TRIM_MSB       = 7;  // result trim code msb
   localparam int ATD_MTRIM_MSB      = 6;  // manual trim msb in ctrl
   localparam int ATD_TRIM_LSB       = 4;  // result trim code lsb
   localparam int ATD_MTRIM_LSB      = 3;  // manual trim lsb in ctrl
   localparam int ATD_TUNE_ERR_BIT   = 3;  // tuning fail flag
   localparam int ATD_DEPTH_SRC_BIT  = 7;  // depth_source_select
   localparam int ATD_LEVEL_MSB      = 6;  // depth level code msb
   localparam int ATD_LEVEL_LSB      = 1;  // depth level code lsb

   // writable bit masks, unused bits read zero
   localparam logic [7:0] ATD_MASK_TUNE_CTRL  = 8'hF8;
   localparam logic [7:0] ATD_MASK_TUNE_RES   = 8'hF8;
   localparam logic [7:0] ATD_MASK_DEPTH_CTRL = 8'hFE;
   localparam logic [7:0] ATD_MASK_FULL       = 8'hFF;

endpackage

// ==== hdl/atd_regs.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : tuning target/result and modulation depth control/result bank
// Assumes : engine and modulator inputs come from logic on MCLK
// Notes   : trim and segment outputs are registered, one cycle behind state
//////////////////////////////////////////////////////////////////////////////
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns

module atd_regs
   import atd_pkg::*;
(
   // clock and reset
   input  wire logic       MCLK,
   input  wire logic       SYS_RST,
   // register port
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // restore-defaults command strobe
   input  wire logic       RESTORE_DEFAULTS,
   // tuning engine result and target
   input  wire logic       TUNE_DONE,
   input  wire logic [3:0] TUNE_CODE,
   input  wire logic       TUNE_FAIL,
   output logic      [7:0] TUNE_TARGET,
   // depth engine result
   input  wire logic       DEPTH_DONE,
   input  wire logic [7:0] DEPTH_MASK,
   input  wire logic [5:0] DEPTH_LEVEL,
   input  wire logic       DEPTH_FAIL,
   // transmitter state
   input  wire logic       AM_MOD,
   // analog controls
   output logic      [3:0] TRIM1_ON,
   output logic      [3:0] TRIM2_ON,
   output logic      [5:0] MOD_LEVEL,
   output logic            DEPTH_MANUAL,
   output logic      [7:0] SEG_OFF
);

   ///////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0] tune_ctrl;
   logic [7:0] tune_target;
   logic [7:0] tune_result;
   logic [7:0] depth_ctrl;
   logic [7:0] depth_result;
   logic [7:0] depth_seg;
   logic       defaults;
   logic [3:0] next_trim;
   logic [7:0] next_seg_off;

   // reset or restore-defaults command
   assign defaults = SYS_RST | RESTORE_DEFAULTS;

   // write strobe for one offset
   function automatic logic wr_hit(input logic       wr,
                                   input logic [7:0] addr,
                                   input logic [7:0] ofs);
      wr_hit = wr && (addr == ofs);
   endfunction

   // readback value for an address, unmapped reads zero
   function automatic logic [7:0] rd_val(input logic [7:0] addr,
                                         input logic [7:0] r21,
                                         input logic [7:0] r22,
                                         input logic [7:0] r23,
                                         input logic [7:0] r24,
                                         input logic [7:0] r25,
                                         input logic [7:0] r26);
      case (addr)
         ATD_OFS_TUNE_CTRL:   rd_val = r21;
         ATD_OFS_TUNE_TARGET: rd_val = r22;
         ATD_OFS_TUNE_RESULT: rd_val = r23;
         ATD_OFS_DEPTH_CTRL:  rd_val = r24;
         ATD_OFS_DEPTH_RES:   rd_val = r25;
         ATD_OFS_DEPTH_SEG:   rd_val = r26;
         default:             rd_val = 8'h00;
      endcase
   endfunction

   ///////////////////////////////////////////////////////////////////////////
   // tuning control: source select and manual trim
   always_ff @(posedge MCLK) begin
      if (defaults) begin
         tune_ctrl <= ATD_RST_TUNE_CTRL;
      end else if (wr_hit(WR, ADDR, ATD_OFS_TUNE_CTRL)) begin
         tune_ctrl <= WDATA & ATD_MASK_TUNE_CTRL;
      end
   end

   always_ff @(posedge MCLK) begin
      if (defaults) begin
         tune_target <= ATD_RST_TUNE_TARGET;
      end else if (wr_hit(WR, ADDR, ATD_OFS_TUNE_TARGET)) begin
         tune_target <= WDATA;
      end
   end

   always_ff @(posedge MCLK) begin
      if (defaults) begin
         tune_result <= ATD_RST_TUNE_RESULT;
      end else if (TUNE_DONE) begin
         tune_result <= {TUNE_CODE, TUNE_FAIL, 3'h0};
      end
   end

   // level code, engine update wins over write
   always_ff @(posedge MCLK) begin
      if (defaults) begin
         depth_ctrl <= ATD_RST_DEPTH_CTRL;
      end else if (DEPTH_DONE && !DEPTH_FAIL) begin
         depth_ctrl[ATD_LEVEL_MSB:ATD_LEVEL_LSB] <= DEPTH_LEVEL;
         if (wr_hit(WR, ADDR, ATD_OFS_DEPTH_CTRL)) begin
            depth_ctrl[ATD_DEPTH_SRC_BIT] <= WDATA[ATD_DEPTH_SRC_BIT];
         end
      end else if (wr_hit(WR, ADDR, ATD_OFS_DEPTH_CTRL)) begin
         depth_ctrl <= WDATA & ATD_MASK_DEPTH_CTRL;
      end
   end

   always_ff @(posedge MCLK) begin
      if (defaults) begin
         depth_result <= ATD_RST_DEPTH_RES;
      end else if (DEPTH_DONE) begin
         depth_result <= DEPTH_FAIL ? ATD_DEPTH_FAIL_MASK : DEPTH_MASK;
      end
   end

   // manual depth segment bits
   always_ff @(posedge MCLK) begin
      if (defaults) begin
         depth_seg <= ATD_RST_DEPTH_SEG;
      end else if (wr_hit(WR, ADDR, ATD_OFS_DEPTH_SEG)) begin
         depth_seg <= WDATA;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // trim source selection
   always_comb begin
      // result code when select is 0
      if (tune_ctrl[ATD_TUNE_SRC_BIT]) begin
         // bit 7 is the select itself, manual code sits below it
         next_trim = tune_ctrl[ATD_MTRIM_MSB:ATD_MTRIM_LSB];
      end else begin
         next_trim = tune_result[ATD_TRIM_MSB:ATD_TRIM_LSB];
      end
   end

   // segment disable during modulation
   always_comb begin
      // manual bits when source is 1
      if (!AM_MOD) begin
         next_seg_off = 8'h00;
      end else if (depth_ctrl[ATD_DEPTH_SRC_BIT]) begin
         next_seg_off = depth_seg;
      end else begin
         next_seg_off = depth_result;
      end
   end

   // same code on both trim groups
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         TRIM1_ON <= 4'h0;
         TRIM2_ON <= 4'h0;
      end else begin
         TRIM1_ON <= next_trim;
         TRIM2_ON <= next_trim;
      end
   end

   // level code and source to modulator
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         MOD_LEVEL    <= 6'h00;
         DEPTH_MANUAL <= 1'b0;
         SEG_OFF      <= 8'h00;
         TUNE_TARGET  <= ATD_RST_TUNE_TARGET;
      end else begin
         MOD_LEVEL    <= depth_ctrl[ATD_LEVEL_MSB:ATD_LEVEL_LSB];
         DEPTH_MANUAL <= depth_ctrl[ATD_DEPTH_SRC_BIT];
         SEG_OFF      <= next_seg_off;
         TUNE_TARGET  <= tune_target;
      end
   end

   // read data one cycle after strobe, zero otherwise
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         RDATA <= rd_val(ADDR, tune_ctrl, tune_target, tune_result,
                         depth_ctrl, depth_result, depth_seg);
      end else begin
         RDATA <= 8'h00;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SYS_RST);

   target_default_a: assert property (RESTORE_DEFAULTS |=>
      tune_target == ATD_RST_TUNE_TARGET)
      else $error("target not defaulted");

   tune_store_a: assert property (TUNE_DONE && !RESTORE_DEFAULTS |=>
      tune_result[7:4] == $past(TUNE_CODE))
      else $error("trim code not stored");

   // result drives trims two cycles on
   trim_auto_a: assert property (TUNE_DONE && !RESTORE_DEFAULTS &&
      !tune_ctrl[ATD_TUNE_SRC_BIT] && !WR && !RESTORE_DEFAULTS ##1
      !RESTORE_DEFAULTS |=> TRIM1_ON == $past(TUNE_CODE, 2))
      else $error("trim not from result");

   trim_pair_a: assert property (TRIM1_ON == TRIM2_ON)
      else $error("trim groups differ");

   tune_fail_a: assert property (TUNE_DONE && !RESTORE_DEFAULTS |=>
      tune_result[ATD_TUNE_ERR_BIT] == $past(TUNE_FAIL) &&
      tune_result[2:0] == 3'h0)
      else $error("fail flag wrong");

   result_clear_a: assert property (RESTORE_DEFAULTS |=>
      tune_result == 8'h00 && depth_result == 8'h00)
      else $error("results not cleared");

   depth_fail_a: assert property (DEPTH_DONE && DEPTH_FAIL &&
      !RESTORE_DEFAULTS |=> depth_result == ATD_DEPTH_FAIL_MASK)
      else $error("fail mask not all ones");

   seg_auto_a: assert property (AM_MOD &&
      !depth_ctrl[ATD_DEPTH_SRC_BIT] |=> SEG_OFF == $past(depth_result))
      else $error("mask not applied");

   // manual segments only with source 1
   seg_manual_a: assert property (AM_MOD &&
      depth_ctrl[ATD_DEPTH_SRC_BIT] |=> SEG_OFF == $past(depth_seg))
      else $error("manual segments not applied");

   rd_unmapped_a: assert property (RD &&
      (ADDR < ATD_OFS_TUNE_CTRL || ADDR > ATD_OFS_DEPTH_SEG) |=>
      RDATA == 8'h00)
      else $error("unmapped read nonzero");

   // manual trim bits drive the trim groups
   trim_manual_a: assert property (tune_ctrl[ATD_TUNE_SRC_BIT] |=>
      TRIM1_ON == $past(tune_ctrl[ATD_MTRIM_MSB:ATD_MTRIM_LSB]))
      else $error("manual trim not applied");

   target_write_a: assert property (WR &&
      ADDR == ATD_OFS_TUNE_TARGET && !RESTORE_DEFAULTS |=>
      tune_target == $past(WDATA))
      else $error("target write lost");

   // target copy reaches the tuning engine
   target_out_a: assert property (1'b1 |=>
      TUNE_TARGET == $past(tune_target))
      else $error("target copy stale");

   depth_mask_a: assert property (DEPTH_DONE && !DEPTH_FAIL &&
      !RESTORE_DEFAULTS |=> depth_result == $past(DEPTH_MASK))
      else $error("depth mask not stored");

   // good calibration loads the level code
   level_load_a: assert property (DEPTH_DONE && !DEPTH_FAIL &&
      !RESTORE_DEFAULTS |=>
      depth_ctrl[ATD_LEVEL_MSB:ATD_LEVEL_LSB] == $past(DEPTH_LEVEL))
      else $error("level code not loaded");

   // failed calibration keeps the level code
   level_keep_a: assert property (DEPTH_DONE && DEPTH_FAIL &&
      !RESTORE_DEFAULTS && !WR |=> $stable(depth_ctrl))
      else $error("level code changed on failure");

   // level code and source reach the modulator
   mod_level_a: assert property (1'b1 |=>
      MOD_LEVEL == $past(depth_ctrl[ATD_LEVEL_MSB:ATD_LEVEL_LSB]) &&
      DEPTH_MANUAL == $past(depth_ctrl[ATD_DEPTH_SRC_BIT]))
      else $error("modulator controls stale");

   // no segment disabled outside AM modulation
   seg_idle_a: assert property (!AM_MOD |=> SEG_OFF == 8'h00)
      else $error("segment off outside modulation");

   // read data zero outside its slot
   rd_slot_a: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data outside slot");

   unused_zero_a: assert property (tune_ctrl[2:0] == 3'h0 &&
      depth_ctrl[0] == 1'b0)
      else $error("unused control bit set");

   // scenarios
   cov_tune: cover property (TUNE_DONE ##1 RD);
   cov_depth_fail: cover property (DEPTH_DONE && DEPTH_FAIL ##2 AM_MOD);
   cov_manual: cover property (depth_ctrl[ATD_DEPTH_SRC_BIT] && AM_MOD);
   cov_restore: cover property (WR ##1 RESTORE_DEFAULTS);

endmodule

// ==== verification/atd_regs_test.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : self-checking bench for the tuning and depth register bank
// Assumes : engine and modulator inputs are synchronous to the bench clock
// Notes   : a monitor pops expected read data off a queue as results appear
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module atd_regs_test
   import atd_pkg::*;
;
   logic       mclk, sys_rst, wr, rd, restore, am_mod, rd_seen;
   logic       tune_done, tune_fail, depth_done, depth_fail, depth_manual;
   logic [7:0] addr, wdata, rdata, tune_target, depth_mask, seg_off, x8;
   logic [3:0] tune_code, trim1, trim2, c4;
   logic [5:0] depth_level, mod_level, l6;
   logic [7:0] exp_q[$];
   // expected state of the analog controls
   logic [3:0] trim_e;
   logic [5:0] lvl_e;
   logic       man_e;
   logic [7:0] seg_e;
   int         fail_count, tests_run;

   atd_regs dut (.MCLK(mclk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .RESTORE_DEFAULTS(restore),
      .TUNE_DONE(tune_done), .TUNE_CODE(tune_code), .TUNE_FAIL(tune_fail),
      .TUNE_TARGET(tune_target), .DEPTH_DONE(depth_done),
      .DEPTH_MASK(depth_mask), .DEPTH_LEVEL(depth_level),
      .DEPTH_FAIL(depth_fail), .AM_MOD(am_mod), .TRIM1_ON(trim1),
      .TRIM2_ON(trim2), .MOD_LEVEL(mod_level), .DEPTH_MANUAL(depth_manual),
      .SEG_OFF(seg_off));

   // clock, 50 ns period
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   //////////////////////////////////////////////////////////////////////////
   task automatic bad(input string msg);
      fail_count++;
      $display("BAD %0t %s", $time, msg);
   endtask

   task automatic cmp8(input logic [7:0] got, exp, input string what);
      tests_run++;
      if (got !== exp) begin
         bad(what);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, e);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      exp_q.push_back(e);
      @(posedge mclk);
      rd   <= 1'b0;
   endtask

   // outputs settle one cycle after the registers
   task automatic chk_outs();
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      cmp8({4'h0, trim1}, {4'h0, trim_e}, "trim group 1");
      cmp8({4'h0, trim2}, {4'h0, trim_e}, "trim group 2");
      cmp8({2'h0, mod_level}, {2'h0, lvl_e}, "modulated level");
      cmp8({7'h0, depth_manual}, {7'h0, man_e}, "depth source");
      cmp8(seg_off, seg_e, "segment disables");
   endtask

   task automatic check_defaults();
      rd_reg(ATD_OFS_TUNE_CTRL, 8'h00);
      rd_reg(ATD_OFS_TUNE_TARGET, 8'h80);
      rd_reg(ATD_OFS_TUNE_RESULT, 8'h00);
      rd_reg(ATD_OFS_DEPTH_CTRL, 8'h00);
      rd_reg(ATD_OFS_DEPTH_RES, 8'h00);
      rd_reg(ATD_OFS_DEPTH_SEG, 8'h00);
      @(negedge mclk);
      cmp8(tune_target, 8'h80, "target output default");
   endtask

   task automatic depth_cal(input logic [7:0] m, input logic [5:0] l,
                            input logic f);
      @(posedge mclk);
      depth_done  <= 1'b1;
      depth_mask  <= m;
      depth_level <= l;
      depth_fail  <= f;
      @(posedge mclk);
      depth_done  <= 1'b0;
      depth_mask  <= ~m;
      depth_level <= ~l;
   endtask

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////////
   // read data monitor, one slot after each read strobe
   always @(posedge mclk) rd_seen <= rd;
   always @(negedge mclk) begin
      if (rd_seen) begin
         if (exp_q.size() == 0) begin
            bad("read data with no expectation");
         end else begin
            cmp8(rdata, exp_q.pop_front(), "read data");
         end
      end else if (!sys_rst && rdata !== 8'h00) begin
         bad("read data outside its slot");
      end
   end

   // watchdog
   initial begin
      repeat (3000) @(posedge mclk);
      bad("timeout");
      give_verdict();
   end

   // main sequence
   initial begin
      {wr, rd, restore, am_mod, tune_done, tune_fail} = 6'h00;
      {depth_done, depth_fail, addr, wdata, depth_mask} = 26'h0;
      {tune_code, depth_level} = 10'h0;
      {trim_e, lvl_e, man_e, seg_e} = 19'h0;
      sys_rst = 1'b1;
      void'($urandom(32'hB349));
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      check_defaults();
      rd_reg(8'h30, 8'h00);
      x8 = 8'($urandom);
      wr_reg(ATD_OFS_TUNE_TARGET, x8);
      rd_reg(ATD_OFS_TUNE_TARGET, x8);
      @(negedge mclk);
      cmp8(tune_target, x8, "target output");
      // read-only places and unused bits
      wr_reg(ATD_OFS_TUNE_RESULT, 8'hFF);
      wr_reg(ATD_OFS_DEPTH_RES, 8'hFF);
      wr_reg(ATD_OFS_TUNE_CTRL, 8'hFF);
      wr_reg(ATD_OFS_DEPTH_CTRL, 8'hFF);
      rd_reg(ATD_OFS_TUNE_RESULT, 8'h00);
      rd_reg(ATD_OFS_DEPTH_RES, 8'h00);
      rd_reg(ATD_OFS_TUNE_CTRL, 8'hF8);
      rd_reg(ATD_OFS_DEPTH_CTRL, 8'hFE);
      wr_reg(ATD_OFS_TUNE_CTRL, 8'h00);
      wr_reg(ATD_OFS_DEPTH_CTRL, 8'h00);
      // tuning outcome, with and without fail
      for (int f = 0; f < 2; f++) begin
         c4 = 4'($urandom);
         @(posedge mclk);
         tune_done <= 1'b1;
         tune_code <= c4;
         tune_fail <= f[0];
         @(posedge mclk);
         tune_done <= 1'b0;
         tune_code <= ~c4;
         rd_reg(ATD_OFS_TUNE_RESULT, {c4, f[0], 3'h0});
         trim_e = c4;
         chk_outs();
      end
      c4 = 4'($urandom);
      wr_reg(ATD_OFS_TUNE_CTRL, {1'b1, c4, 3'h0});
      trim_e = c4;
      chk_outs();
      l6 = 6'($urandom);
      wr_reg(ATD_OFS_DEPTH_CTRL, {1'b0, l6, 1'b0});
      lvl_e = l6;
      chk_outs();
      x8 = 8'($urandom);
      l6 = 6'($urandom);
      depth_cal(x8, l6, 1'b0);
      am_mod <= 1'b1;
      rd_reg(ATD_OFS_DEPTH_RES, x8);
      rd_reg(ATD_OFS_DEPTH_CTRL, {1'b0, l6, 1'b0});
      {lvl_e, seg_e} = {l6, x8};
      chk_outs();
      depth_cal(8'h5A, ~l6, 1'b1);
      rd_reg(ATD_OFS_DEPTH_RES, ATD_DEPTH_FAIL_MASK);
      seg_e = 8'hFF;
      chk_outs();
      x8 = 8'($urandom);
      wr_reg(ATD_OFS_DEPTH_SEG, x8);
      wr_reg(ATD_OFS_DEPTH_CTRL, {1'b1, l6, 1'b0});
      {man_e, seg_e} = {1'b1, x8};
      chk_outs();
      @(posedge mclk);
      am_mod <= 1'b0;
      seg_e = 8'h00;
      chk_outs();
      // restore-defaults command
      @(posedge mclk);
      restore <= 1'b1;
      @(posedge mclk);
      restore <= 1'b0;
      check_defaults();
      {trim_e, lvl_e, man_e, seg_e} = 19'h0;
      chk_outs();
      if (exp_q.size() != 0) begin
         bad("reads left unanswered");
      end
      give_verdict();
   end
endmodule
